// ===== mtx_pkg.sv
// Constants, types and helpers shared by the MII transmit side
// Overview of operation
// - At 100 Mb/s the transmit clock output runs at 25 MHz, one nibble per cycle.
// - At 10 Mb/s nibble operation the transmit clock output runs at 2.5 MHz.
// - At 10 Mb/s serial operation the transmit clock output runs at 10 MHz.
// - In nibble operation four data bits are taken as one nibble per clock.
// - In serial operation only data bit 0 is used; bits 3:1 are ignored.
// - In nibble operation data counts as valid only while transmit enable is high; in either bypass at 100 Mb/s the code marks every sample valid.
// - In serial operation enable high marks bit 0 as frame data for the frame.
// - At 100 Mb/s without encoder bypass, error with enable high replaces the nibble by the halt symbol.
// - At 10 Mb/s the transmit error input has no effect at all.
// - At 100 Mb/s, in either encoder bypass the error input becomes the fifth code bit.
package mtx_pkg;

    localparam int CLK_HZ = 125_000_000;
    localparam int TXC_100_HZ = 25_000_000;
    localparam int TXC_10N_HZ = 2_500_000;
    localparam int TXC_10S_HZ = 10_000_000;

    // Length of two transmit clock periods in system cycles
    localparam int DBL_100_CYC = (2 * CLK_HZ) / TXC_100_HZ;
    localparam int DBL_10N_CYC = (2 * CLK_HZ) / TXC_10N_HZ;
    localparam int DBL_10S_CYC = (2 * CLK_HZ) / TXC_10S_HZ;

    localparam int CNT_W = 7;

    localparam logic [4:0] HALT_CODE = 5'h04;
    localparam logic [4:0] CODE_RST = 5'h00;

    typedef enum logic [2:0] {
        MTX_MODE_100 = 3'b001,
        MTX_MODE_10N = 3'b010,
        MTX_MODE_10S = 3'b100
    } mtx_mode_t;

    localparam mtx_mode_t MODE_RST = MTX_MODE_10N;

    typedef enum logic [2:0] {
        MTX_ST_RESYNC = 3'b001,
        MTX_ST_IDLE = 3'b010,
        MTX_ST_FRAME = 3'b100
    } mtx_state_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] txd;
    } mtx_mii_t;

    typedef struct packed {
        logic valid;
        logic halt;
        logic serial;
        logic [4:0] code;
    } mtx_sym_t;

    localparam mtx_mii_t MII_RST = '{en: 1'b0, er: 1'b0, txd: 4'h0};
    localparam mtx_sym_t SYM_RST = '{valid: 1'b0, halt: 1'b0, serial: 1'b0, code: CODE_RST};

    function automatic logic [CNT_W-1:0] mtx_dbl_cycles(input mtx_mode_t mode);
        logic [CNT_W-1:0] d;
        d = CNT_W'(DBL_10N_CYC);
        case (mode)
            MTX_MODE_100: d = CNT_W'(DBL_100_CYC);
            MTX_MODE_10S: d = CNT_W'(DBL_10S_CYC);
            default: d = CNT_W'(DBL_10N_CYC);
        endcase
        return d;
    endfunction : mtx_dbl_cycles

    function automatic mtx_mode_t mtx_pick_mode(input logic speed_100, input logic serial_10);
        mtx_mode_t m;
        m = MTX_MODE_10N;
        if (speed_100) begin
            m = MTX_MODE_100;
        end else if (serial_10) begin
            m = MTX_MODE_10S;
        end
        return m;
    endfunction : mtx_pick_mode

endpackage : mtx_pkg

// ===== mtx_clkgen.sv
// Transmit clock divider with a sampling strobe at each rising edge
module mtx_clkgen (
    input wire logic clock,
    input wire logic resetn,
    input mtx_pkg::mtx_mode_t mode,
    input wire logic restart,
    output logic tx_clk,
    output logic rise
);
    import mtx_pkg::*;

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic odd_r;
    logic odd_nxt;
    logic tx_clk_r;
    logic [CNT_W-1:0] dbl;
    logic [CNT_W-1:0] per_a;
    logic [CNT_W-1:0] period;
    logic wrap;
    logic [CNT_W-1:0] half;

    // Two periods of dbl cycles; an odd total alternates floor and ceil lengths
    assign dbl = mtx_dbl_cycles(mode);
    assign per_a = dbl >> 1;
    assign period = odd_r ? (dbl - per_a) : per_a;
    assign half = period >> 1;
    assign wrap = (cnt_r == period - 7'h01);

    always_comb begin
        cnt_nxt = cnt_r + 7'h01;
        odd_nxt = odd_r;
        if (restart) begin
            cnt_nxt = '0;
            odd_nxt = 1'b0;
        end else if (wrap) begin
            cnt_nxt = '0;
            odd_nxt = ~odd_r;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            odd_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            odd_r <= odd_nxt;
        end
    end

    // Low half first; the output rises as the counter reaches the half point,
    // and rise marks that same clock edge so sampling and the edge coincide
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_clk_r <= 1'b0;
        end else begin
            tx_clk_r <= !restart && (cnt_nxt >= half);
        end
    end

    assign tx_clk = tx_clk_r;
    assign rise = !restart && (cnt_nxt == half);

endmodule : mtx_clkgen

// ===== mtx_transmit.sv
// MII transmit side: clock output, input sampling and symbol substitution
module mtx_transmit (
    input wire logic clock,
    input wire logic resetn,
    input wire logic speed_100,
    input wire logic serial_10,
    input wire logic code_group_bypass,
    input wire logic alignment_bypass,
    input mtx_pkg::mtx_mii_t mii_in,
    output logic tx_clk,
    output mtx_pkg::mtx_sym_t sym_out,
    output logic sym_strobe,
    output logic tx_active,
    output logic frame_end,
    output logic frame_halted
);
    import mtx_pkg::*;

    mtx_mii_t mii_s1_r;
    mtx_mii_t mii_s2_r;
    mtx_mode_t mode_r;
    mtx_mode_t mode_nxt;
    mtx_state_t state_r;
    mtx_state_t state_nxt;
    mtx_sym_t sym_r;
    mtx_sym_t sym_nxt;
    logic bypass_r;
    logic restart;
    logic rise;
    logic strobe_r;
    logic end_r;
    logic halted_r;
    logic frame_on;
    logic active_r;
    logic take;

    // Mode pins come from the same clock domain. Any change restarts the
    // divider at once (a change of serial_10 while speed_100 is high is none), so the new rate always starts from a clean low phase
    // and no symbol of the old mode is mistaken for one of the new.
    assign mode_nxt = mtx_pick_mode(speed_100, serial_10);
    assign restart = (mode_nxt != mode_r);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_r <= MODE_RST;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Either bypass setting frees the error pin as a fifth code bit.
    // The one cycle of lag is harmless for a level that changes rarely;
    // it only acts at 100 Mb/s, where the error pin has a meaning.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bypass_r <= 1'b0;
        end else begin
            bypass_r <= code_group_bypass || alignment_bypass;
        end
    end

    // Divider makes the transmit clock and marks each of its rising edges
    mtx_clkgen u_clkgen (
        .clock(clock),
        .resetn(resetn),
        .mode(mode_r),
        .restart(restart),
        .tx_clk(tx_clk),
        .rise(rise)
    );

    // MAC pins are two-stage synchronised; they have been steady since the
    // previous rising edge, so the synchronised copy is settled at the next one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mii_s1_r <= MII_RST;
            mii_s2_r <= MII_RST;
        end else begin
            mii_s1_r <= mii_in;
            mii_s2_r <= mii_s1_r;
        end
    end

    // Frame tracking: a resync period follows any mode change. It waits for a
    // rise with enable low, so the tail of a frame cut by a mode change is dropped.
    assign frame_on = mii_s2_r.en;

    // A sample counts once resync is over
    assign take = rise && (state_r != MTX_ST_RESYNC);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MTX_ST_RESYNC: begin
                if (rise && !frame_on) begin
                    state_nxt = MTX_ST_IDLE;
                end
            end
            MTX_ST_IDLE: begin
                if (rise && frame_on) begin
                    state_nxt = MTX_ST_FRAME;
                end
            end
            MTX_ST_FRAME: begin
                if (rise && !frame_on) begin
                    state_nxt = MTX_ST_IDLE;
                end
            end
            default: begin
                state_nxt = MTX_ST_RESYNC;
            end
        endcase
        if (restart) begin
            state_nxt = MTX_ST_RESYNC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= MTX_ST_RESYNC;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Symbol built from the sample taken at each transmit clock rising edge
    always_comb begin
        sym_nxt = SYM_RST;
        case (mode_r)
            MTX_MODE_100: begin
                // Bypass hands over the raw five-bit group on every clock
                if (bypass_r) begin
                    sym_nxt.valid = 1'b1;
                    sym_nxt.code = {mii_s2_r.er, mii_s2_r.txd};
                end else if (mii_s2_r.en && mii_s2_r.er) begin
                    sym_nxt.valid = 1'b1;
                    sym_nxt.halt = 1'b1;
                    sym_nxt.code = HALT_CODE;
                end else if (mii_s2_r.en) begin
                    sym_nxt.valid = 1'b1;
                    sym_nxt.code = {1'b0, mii_s2_r.txd};
                end
            end
            MTX_MODE_10S: begin
                // Only the lowest data pin counts; the error pin is ignored
                sym_nxt.serial = 1'b1;
                if (mii_s2_r.en) begin
                    sym_nxt.valid = 1'b1;
                    sym_nxt.code = {4'h0, mii_s2_r.txd[0]};
                end
            end
            default: begin
                // Nibble at 10 Mb/s: the error pin is ignored
                if (mii_s2_r.en) begin
                    sym_nxt.valid = 1'b1;
                    sym_nxt.code = {1'b0, mii_s2_r.txd};
                end
            end
        endcase
        if (state_r == MTX_ST_RESYNC) begin
            sym_nxt = SYM_RST;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sym_r <= SYM_RST;
        end else if (restart) begin
            // The held symbol of the old mode is dropped at once
            sym_r <= SYM_RST;
        end else if (rise) begin
            sym_r <= sym_nxt;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            strobe_r <= 1'b0;
        end else begin
            // Marks the cycle in which a new symbol first stands
            strobe_r <= take;
        end
    end

    // End of frame pulse and a level telling whether the frame carried a halt.
    // A restart that cuts a frame gives the end pulse as well.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            end_r <= 1'b0;
        end else begin
            end_r <= (state_r == MTX_ST_FRAME) && (state_nxt != MTX_ST_FRAME);
        end
    end

    // The first sample of a frame restarts the flag, so a halt from an
    // earlier frame never leaks into the next one
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            halted_r <= 1'b0;
        end else if (rise && (state_r == MTX_ST_IDLE) && frame_on) begin
            halted_r <= sym_nxt.halt;
        end else if (rise && (state_r == MTX_ST_FRAME) && sym_nxt.halt) begin
            halted_r <= 1'b1;
        end
    end

    // Frame level from a flop that follows the tracking state
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            active_r <= 1'b0;
        end else begin
            active_r <= (state_nxt == MTX_ST_FRAME);
        end
    end

    assign sym_out = sym_r;
    assign sym_strobe = strobe_r;
    assign tx_active = active_r;
    assign frame_end = end_r;
    assign frame_halted = halted_r;

endmodule : mtx_transmit

// ===== mtx_transmit_checker.sv
// Port assertions for the MII transmit side
module mtx_transmit_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic speed_100,
    input wire logic serial_10,
    input wire logic code_group_bypass,
    input wire logic alignment_bypass,
    input mtx_pkg::mtx_mii_t mii_in,
    input wire logic tx_clk,
    input mtx_pkg::mtx_sym_t sym_out,
    input wire logic sym_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import mtx_pkg::*;
    logic [3:0] mq_r;
    logic [6:0] st_r, hi_r, lo_r;
    mtx_mii_t [3:0] pin_r;
    wire mtx_mii_t pd = pin_r[3];
    wire logic [3:0] mv = {speed_100, serial_10, code_group_bypass, alignment_bypass};
    wire logic chg = mv != mq_r;
    wire logic byp = code_group_bypass | alignment_bypass;
    wire logic ok = st_r > 7'd60;
    // Phase lengths and pins seen four cycles back
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mq_r <= 4'h0;
            st_r <= 7'h00;
            hi_r <= 7'h00;
            lo_r <= 7'h00;
            pin_r <= '0;
        end else begin
            mq_r <= mv;
            st_r <= chg ? 7'h00 : st_r + 7'(st_r != 7'h7f);
            hi_r <= tx_clk ? hi_r + 7'h01 : 7'h00;
            lo_r <= tx_clk ? 7'h00 : lo_r + 7'h01;
            pin_r <= {pin_r[2:0], mii_in};
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn || chg);
    sequence s_quiet;
        !sym_strobe [*3];
    endsequence
    property p_strobe;
        sym_strobe |-> $rose(tx_clk) ##1 s_quiet;
    endproperty
    property p_per_100;
        ok && speed_100 |-> (hi_r == 0 || tx_clk || hi_r == 3) && (lo_r == 0 || !tx_clk || lo_r == 2);
    endproperty
    property p_per_10n;
        ok && !speed_100 && !serial_10 |-> (hi_r == 0 || tx_clk || hi_r == 25)
            && (lo_r == 0 || !tx_clk || lo_r == 25);
    endproperty
    property p_per_10s;
        ok && !speed_100 && serial_10 |-> (hi_r == 0 || tx_clk || hi_r == 6 || hi_r == 7)
            && (lo_r == 0 || !tx_clk || lo_r == 6);
    endproperty
    property p_nib_100;
        sym_strobe && speed_100 && !byp && !pd.er |-> sym_out.valid == pd.en
            && (!pd.en || sym_out.code == {1'b0, pd.txd});
    endproperty
    property p_halt;
        sym_strobe && speed_100 && !byp && pd.en && pd.er |-> sym_out.halt && sym_out.code == HALT_CODE;
    endproperty
    property p_nib_10;
        sym_strobe && !speed_100 && !serial_10 && pd.en |-> sym_out.valid && !sym_out.halt
            && sym_out.code == {1'b0, pd.txd};
    endproperty
    property p_serial;
        sym_strobe && !speed_100 && serial_10 && pd.en |-> sym_out.valid && sym_out.serial
            && !sym_out.halt && sym_out.code[0] == pd.txd[0];
    endproperty
    property p_bypass;
        sym_strobe && speed_100 && byp |-> sym_out.valid && sym_out.code == {pd.er, pd.txd};
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe off the clock rise");
    a_per_100: assert property (p_per_100) else $error("bad 100M clock phase");
    a_per_10n: assert property (p_per_10n) else $error("bad 10M nibble clock phase");
    a_per_10s: assert property (p_per_10s) else $error("bad 10M serial clock phase");
    a_nib_100: assert property (p_nib_100) else $error("bad 100M nibble");
    a_halt: assert property (p_halt) else $error("halt symbol missing");
    a_nib_10: assert property (p_nib_10) else $error("10M nibble altered");
    a_serial: assert property (p_serial) else $error("bad serial bit");
    a_bypass: assert property (p_bypass) else $error("bad bypass code");
endmodule : mtx_transmit_checker

bind mtx_transmit mtx_transmit_checker mtx_transmit_checker_i (.clock, .resetn, .speed_100,
    .serial_10, .code_group_bypass, .alignment_bypass, .mii_in, .tx_clk, .sym_out, .sym_strobe);

// ===== mtx_mac_model.sv
// Behavioural MAC that drives the MII transmit pins
module mtx_mac_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tx_clk,
    input wire logic req,
    input wire logic [7:0] len,
    input wire logic [7:0] er_at,
    output mtx_pkg::mtx_mii_t mii,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    import mtx_pkg::*;
    logic tx_r = 1'b0;
    logic [7:0] idx_r = 8'h00;
    always @(negedge clock) begin
        tx_r <= tx_clk;
        if (!resetn) begin
            mii <= MII_RST;
            busy <= 1'b0;
            idx_r <= 8'h00;
        end else if (tx_clk && !tx_r) begin
            if ((busy || req) && idx_r < len) begin
                mii <= '{en: 1'b1, er: idx_r == er_at, txd: 4'(idx_r * 7 + 2)};
                busy <= 1'b1;
                idx_r <= idx_r + 8'h01;
            end else begin
                // Idle data lines keep toggling so stale values never look valid
                mii <= '{en: 1'b0, er: 1'b0, txd: ~mii.txd};
                busy <= 1'b0;
                idx_r <= 8'h00;
            end
        end
    end
endmodule : mtx_mac_model

// ===== testbench.sv
// Self-checking bench for the MII transmit side
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mtx_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic speed_100 = 1'b0;
    logic serial_10 = 1'b0;
    logic code_group_bypass = 1'b0;
    logic alignment_bypass = 1'b0;
    logic req = 1'b0;
    logic [7:0] len = 8'h00;
    logic [7:0] er_at = 8'hff;
    logic tx_clk, sym_strobe, frame_halted, busy, tx_active, frame_end;
    mtx_mii_t mii_in;
    mtx_sym_t sym_out;
    mtx_sym_t rx_q[$];
    int n_errors = 0;
    int n_tests = 0;
    always #4 clock = ~clock;
    mtx_transmit mtx_transmit_i (.clock, .resetn, .speed_100, .serial_10, .code_group_bypass,
        .alignment_bypass, .mii_in, .tx_clk, .sym_out, .sym_strobe, .tx_active, .frame_end,
        .frame_halted);
    mtx_mac_model mtx_mac_model_i (.clock, .resetn, .tx_clk, .req, .len, .er_at, .mii(mii_in),
        .busy);
    always @(posedge clock) begin
        if (sym_strobe === 1'b1 && sym_out.valid === 1'b1) begin
            rx_q.push_back(sym_out);
        end
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    function automatic logic [3:0] nib(input int i);
        return 4'(i * 7 + 2);
    endfunction : nib
    // Change mode, then wait for two strobes so resync is over
    task automatic set_mode(input logic f, input logic s, input logic [1:0] b);
        int k;
        @(negedge clock);
        speed_100 = f;
        serial_10 = s;
        {alignment_bypass, code_group_bypass} = b;
        repeat (2) begin
            k = 0;
            do begin
                @(negedge clock);
                k++;
            end while (sym_strobe !== 1'b1 && k < 400);
            if (k >= 400) begin
                n_errors++;
                end_sim();
            end
        end
    endtask : set_mode
    task automatic send(input int n, input int e, input int need);
        int k;
        for (k = 0; k < 900 && busy !== 1'b0; k++) @(negedge clock);
        if (k >= 900) begin
            n_errors++;
            end_sim();
        end
        rx_q.delete();
        len = 8'(n);
        er_at = 8'(e);
        req = 1'b1;
        for (; k < 9000 && rx_q.size() < need; k++) begin
            @(negedge clock);
            if (busy === 1'b1) req = 1'b0;
        end
        if (k >= 9000) begin
            n_errors++;
            end_sim();
        end
    endtask : send
    // Frame still tracked after its last symbol, then one end pulse as it drops
    task automatic chk_end();
        int k;
        `CHK(tx_active, 1'b1)
        for (k = 0; k < 200 && frame_end !== 1'b1; k++) @(negedge clock);
        `CHK({frame_end, tx_active}, 2'b10)
    endtask : chk_end
    task automatic t_100();
        set_mode(1'b1, 1'b0, 2'b00);
        send(8, 3, 8);
        `CHK(rx_q.size(), 8)
        foreach (rx_q[i]) begin
            `CHK(rx_q[i].code, i == 3 ? HALT_CODE : {1'b0, nib(i)})
            `CHK(rx_q[i].halt, i == 3)
        end
        `CHK(frame_halted, 1'b1)
        chk_end();
    endtask : t_100
    task automatic t_10n();
        set_mode(1'b0, 1'b0, 2'b00);
        send(6, 2, 6);
        `CHK(rx_q.size(), 6)
        foreach (rx_q[i]) begin
            `CHK({rx_q[i].halt, rx_q[i].code}, {2'b00, nib(i)})
        end
        `CHK(frame_halted, 1'b0)
        chk_end();
    endtask : t_10n
    task automatic t_10s();
        set_mode(1'b0, 1'b1, 2'b00);
        send(6, 1, 6);
        `CHK(rx_q.size(), 6)
        foreach (rx_q[i]) begin
            `CHK({rx_q[i].halt, rx_q[i].serial, rx_q[i].code[0]}, {2'b01, 1'(nib(i))})
        end
        chk_end();
    endtask : t_10s
    task automatic t_byp();
        int hits;
        for (int b = 1; b < 3; b++) begin
            set_mode(1'b1, 1'b0, 2'(b));
            send(4, 2, 8);
            hits = 0;
            foreach (rx_q[i]) begin
                hits += int'(rx_q[i].code === {1'b1, nib(2)} && rx_q[i].halt === 1'b0);
            end
            `CHK(hits, 1)
        end
    endtask : t_byp
    initial begin
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        t_100();
        t_10n();
        t_10s();
        t_byp();
        end_sim();
    end
endmodule : testbench
